//--- core/tasc_core.sv
// status and configuration registers of a two-channel temperature monitor
//
// How it works
// - status bit 7 shows converter busy
// - bit 6 flags local above high limit
// - bit 4 flags remote above high limit
// - bit 3 flags remote below low limit
// - bit 2 shows remote channel disconnected
// - disconnect flag never drives alert pins
// - bit 1 flags remote above critical limit
// - bit 0 flags local above critical limit
// - busy setup write restarts unless it selects shutdown, applies after finish
// - alert read sets mask; host clears it
// - mask set keeps alert pin released
// - mode bit: continuous or shutdown
// - bit 2 enables remote monitoring, resets one
// - critical limits writable only when unlocked
// - fault queue needs three successive results
// - debounce only on remote checks
// - status read clears limit flags
// - alert response sets mask, keeps flags
// - one-shot write converts once in shutdown
module tasc_core (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// register port
	input wire tasc_pkg::tasc_reg_req_t req,
	output logic [7:0] reg_rdata,
	// alert response address
	input wire logic ara_req,
	output logic ara_ack,
	// converter
	input wire logic conv_tick,
	input wire logic conv_done,
	input wire tasc_pkg::tasc_result_t result,
	input wire tasc_pkg::tasc_limits_t limits,
	output logic conv_start,
	output logic conv_abort,
	output logic conv_remote_en,
	// open-drain pins
	output logic alert_o,
	output logic alert_oe,
	output logic crit_o,
	output logic crit_oe
);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// limits compare as two's complement
	function automatic logic above(logic [10:0] a, logic [10:0] b);
		return $signed(a) > $signed(b);
	endfunction

	// 8-bit values sign-extend into the low bits of 11-bit remote words, with no shift
	function automatic logic [10:0] widen(logic [7:0] v);
		return {{3{v[7]}}, v};
	endfunction

	tasc_pkg::tasc_core_state_t q;
	tasc_pkg::tasc_core_state_t n;

	logic busy;
	logic done;
	logic cfg_wr;
	logic status_rd;
	logic oneshot_wr;
	logic busy_now;
	logic [2:0] beyond;
	logic [2:0] fq_hit;

	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	// the alternate setup offset behaves the same as the primary one
	assign busy = q.st == tasc_pkg::CONV_BUSY;
	assign done = busy && conv_done;
	assign busy_now = busy && !conv_done;
	assign cfg_wr = req.wr && (req.addr == tasc_pkg::ADDR_CFG ||
		req.addr == tasc_pkg::ADDR_CFG_ALT);
	assign status_rd = req.rd && req.addr == tasc_pkg::ADDR_STATUS;
	assign oneshot_wr = req.wr && req.addr == tasc_pkg::ADDR_ONESHOT;

	// ----------------------------------------------------------------
	// remote checks through the fault queue
	// ----------------------------------------------------------------
	// remote gating
	// a disabled channel reports nothing and its queue empties
	always_comb begin
		beyond = 3'h0;
		if (q.cfg[tasc_pkg::CFG_REMOTE_EN]) begin
			beyond[tasc_pkg::FQ_HIGH] =
				above(result.remote_temp, limits.remote_high);
			beyond[tasc_pkg::FQ_LOW] =
				above(limits.remote_low, result.remote_temp);
			beyond[tasc_pkg::FQ_CRIT] =
				above(result.remote_temp, widen(q.crit_remote));
		end
	end

	tasc_fault_queue u_fq (
		.clk(clk),
		.rst(rst),
		.sample(done),
		.queue_on(q.cfg[tasc_pkg::CFG_FAULT_Q]),
		.beyond(beyond),
		.hit(fq_hit)
	);

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		n = q;
		n.start_p = 1'b0;
		n.abort_p = 1'b0;
		n.ara_ack = 1'b0;

		// register reads; reserved offsets return zero
		if (req.rd) begin
			case (req.addr)
				tasc_pkg::ADDR_STATUS: n.rdata = {busy, q.flags[6:0]};
				tasc_pkg::ADDR_CFG: n.rdata = q.cfg;
				tasc_pkg::ADDR_CFG_ALT: n.rdata = q.cfg;
				tasc_pkg::ADDR_CRIT_REMOTE: n.rdata = q.crit_remote;
				tasc_pkg::ADDR_CRIT_LOCAL: n.rdata = q.crit_local;
				default: n.rdata = 8'h00;
			endcase
		end

		// read clears
		// cleared first so a result landing now still sets its flag
		if (status_rd) begin
			n.flags = q.flags & ~tasc_pkg::LIMIT_FLAGS;
		end

		// conversion sequencing
		case (q.st)
			tasc_pkg::CONV_IDLE: begin
				if ((!q.cfg[tasc_pkg::CFG_MODE] && conv_tick) ||
					(q.cfg[tasc_pkg::CFG_MODE] && oneshot_wr)) begin
					n.st = tasc_pkg::CONV_BUSY;
					n.start_p = 1'b1;
				end
			end
			tasc_pkg::CONV_BUSY: begin
				if (conv_done) begin
					n.st = tasc_pkg::CONV_IDLE;
					if (q.pend_v) begin
						n.cfg = q.pend_cfg;
					end
					n.pend_v = 1'b0;
					if (above(widen(result.local_temp),
						widen(limits.local_high))) begin
						n.flags[tasc_pkg::BIT_LOCAL_HIGH] = 1'b1;
					end
					if (above(widen(result.local_temp),
						widen(q.crit_local))) begin
						n.flags[tasc_pkg::BIT_LOCAL_CRIT] = 1'b1;
					end
					if (fq_hit[tasc_pkg::FQ_HIGH]) begin
						n.flags[tasc_pkg::BIT_REMOTE_HIGH] = 1'b1;
					end
					if (fq_hit[tasc_pkg::FQ_LOW]) begin
						n.flags[tasc_pkg::BIT_REMOTE_LOW] = 1'b1;
					end
					if (fq_hit[tasc_pkg::FQ_CRIT]) begin
						n.flags[tasc_pkg::BIT_REMOTE_CRIT] = 1'b1;
					end
					n.flags[tasc_pkg::BIT_REMOTE_OPEN] =
						q.cfg[tasc_pkg::CFG_REMOTE_EN] && result.remote_open;
				end
			end
			default: n.st = tasc_pkg::CONV_IDLE;
		endcase

		// busy write
		// a write into a running conversion waits in pend_cfg
		if (cfg_wr) begin
			if (busy_now) begin
				n.pend_cfg = req.wdata & tasc_pkg::CFG_WRITABLE;
				n.pend_v = 1'b1;
				n.abort_p = !req.wdata[tasc_pkg::CFG_MODE];
			end else begin
				n.cfg = req.wdata & tasc_pkg::CFG_WRITABLE;
			end
		end

		if (req.wr && q.cfg[tasc_pkg::CFG_CRIT_UNLOCK]) begin
			if (req.addr == tasc_pkg::ADDR_CRIT_REMOTE) begin
				n.crit_remote = req.wdata;
			end
			if (req.addr == tasc_pkg::ADDR_CRIT_LOCAL) begin
				n.crit_local = req.wdata;
			end
		end

		// mask on read
		// mask also goes into a pending setup so it is not undone
		if (status_rd && q.alert_oe) begin
			n.cfg[tasc_pkg::CFG_ALERT_MASK] = 1'b1;
			n.pend_cfg[tasc_pkg::CFG_ALERT_MASK] = 1'b1;
		end

		if (ara_req && q.alert_oe) begin
			n.cfg[tasc_pkg::CFG_ALERT_MASK] = 1'b1;
			n.pend_cfg[tasc_pkg::CFG_ALERT_MASK] = 1'b1;
			n.ara_ack = 1'b1;
		end

		n.alert_oe = !n.cfg[tasc_pkg::CFG_ALERT_MASK] &&
			|(n.flags & tasc_pkg::ALERT_SRC);
		n.crit_oe = |(n.flags & tasc_pkg::CRIT_SRC);
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			q.st <= tasc_pkg::CONV_IDLE;
			q.flags <= tasc_pkg::RST_STATUS;
			q.cfg <= tasc_pkg::RST_CFG;
			q.pend_cfg <= tasc_pkg::RST_CFG;
			q.pend_v <= 1'b0;
			q.crit_remote <= tasc_pkg::RST_CRIT;
			q.crit_local <= tasc_pkg::RST_CRIT;
			q.rdata <= 8'h00;
			q.start_p <= 1'b0;
			q.abort_p <= 1'b0;
			q.ara_ack <= 1'b0;
			q.alert_oe <= 1'b0;
			q.crit_oe <= 1'b0;
		end else begin
			q <= n;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	// open-drain pins only ever pull low
	assign reg_rdata = q.rdata;
	assign ara_ack = q.ara_ack;
	assign conv_start = q.start_p;
	assign conv_abort = q.abort_p;
	assign conv_remote_en = q.cfg[tasc_pkg::CFG_REMOTE_EN];
	assign alert_o = 1'b0;
	assign alert_oe = q.alert_oe;
	assign crit_o = 1'b0;
	assign crit_oe = q.crit_oe;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence s_local_high_done;
		done && !status_rd &&
		above(widen(result.local_temp), widen(limits.local_high));
	endsequence

	sequence s_busy_cfg_wr;
		cfg_wr && busy_now && !req.wdata[tasc_pkg::CFG_MODE];
	endsequence

	property p_busy_rd;
		status_rd |=> reg_rdata[tasc_pkg::BIT_BUSY] == $past(busy);
	endproperty
	a_busy_rd: assert property (p_busy_rd)
		else $error("busy bit readback wrong");

	property p_local_high;
		s_local_high_done |=> q.flags[tasc_pkg::BIT_LOCAL_HIGH];
	endproperty
	a_local_high: assert property (p_local_high)
		else $error("local high flag not set");

	property p_pins_quiet;
		(q.flags & tasc_pkg::LIMIT_FLAGS) == 8'h00 |-> !alert_oe && !crit_oe;
	endproperty
	a_pins_quiet: assert property (p_pins_quiet)
		else $error("pin driven without a limit flag");

	property p_busy_write;
		s_busy_cfg_wr |=> conv_abort && q.pend_v &&
			q.cfg == $past(q.cfg);
	endproperty
	a_busy_write: assert property (p_busy_write)
		else $error("busy setup write not deferred");

	property p_mask_quiet;
		q.cfg[tasc_pkg::CFG_ALERT_MASK] |-> !alert_oe;
	endproperty
	a_mask_quiet: assert property (p_mask_quiet)
		else $error("alert driven while masked");

	property p_read_mask;
		status_rd && alert_oe |=> q.cfg[tasc_pkg::CFG_ALERT_MASK] ##1
			!alert_oe;
	endproperty
	a_read_mask: assert property (p_read_mask)
		else $error("alert read did not mask");

	property p_shutdown_idle;
		q.cfg[tasc_pkg::CFG_MODE] && !oneshot_wr |=> !conv_start;
	endproperty
	a_shutdown_idle: assert property (p_shutdown_idle)
		else $error("conversion started in shutdown");

	property p_crit_lock;
		!q.cfg[tasc_pkg::CFG_CRIT_UNLOCK] |=>
			q.crit_local == $past(q.crit_local) &&
			q.crit_remote == $past(q.crit_remote);
	endproperty
	a_crit_lock: assert property (p_crit_lock)
		else $error("locked critical limit changed");

	property p_read_clear;
		status_rd && !done |=> (q.flags & tasc_pkg::LIMIT_FLAGS) == 8'h00;
	endproperty
	a_read_clear: assert property (p_read_clear)
		else $error("status read left limit flags");

	property p_ara;
		ara_req && alert_oe && !done && !status_rd |=>
			ara_ack && q.cfg[tasc_pkg::CFG_ALERT_MASK] &&
			q.flags == $past(q.flags);
	endproperty
	a_ara: assert property (p_ara)
		else $error("alert response handled wrong");

	property p_oneshot;
		!busy && q.cfg[tasc_pkg::CFG_MODE] && oneshot_wr |=>
			conv_start ##1 !conv_start;
	endproperty
	a_oneshot: assert property (p_oneshot)
		else $error("one-shot did not start once");

endmodule

//--- core/tasc_fault_queue.sv
// consecutive-result debounce for the three remote limit checks
module tasc_fault_queue (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// one remote result per completed conversion
	input wire logic sample,
	input wire logic queue_on,
	input wire logic [2:0] beyond,
	// qualified violations, valid with sample
	output logic [2:0] hit
);

	tasc_pkg::tasc_fq_state_t q;
	tasc_pkg::tasc_fq_state_t n;

	// ----------------------------------------------------------------
	// run counters
	// ----------------------------------------------------------------
	// three in a row
	// a counter saturates at two earlier hits; the third one qualifies
	always_comb begin
		n = q;
		hit = 3'h0;
		for (int i = 0; i < tasc_pkg::FQ_CHANNELS; i++) begin
			hit[i] = sample && beyond[i] &&
				(!queue_on || q.run[i] >= tasc_pkg::FQ_PRIOR);
			if (sample) begin
				if (!beyond[i]) begin
					n.run[i] = 2'h0;
				end else if (q.run[i] < tasc_pkg::FQ_PRIOR) begin
					n.run[i] = q.run[i] + 2'h1;
				end
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			q <= '0;
		end else begin
			q <= n;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	property p_fq_single;
		@(posedge clk) disable iff (rst)
		sample && queue_on && q.run[0] == 2'h0 |-> !hit[0];
	endproperty
	a_fq_single: assert property (p_fq_single)
		else $error("fault queue passed a single result");

	property p_fq_off;
		@(posedge clk) disable iff (rst)
		sample && !queue_on |-> hit == beyond;
	endproperty
	a_fq_off: assert property (p_fq_off)
		else $error("disabled fault queue still filters");

endmodule

//--- inc/tasc_pkg.sv
// constants, carriers and state types of the temperature alert status block
package tasc_pkg;

	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_STATUS = 8'h02;
	localparam logic [7:0] ADDR_CFG = 8'h03;
	localparam logic [7:0] ADDR_CFG_ALT = 8'h09;
	localparam logic [7:0] ADDR_ONESHOT = 8'h0f;
	localparam logic [7:0] ADDR_CRIT_REMOTE = 8'h19;
	localparam logic [7:0] ADDR_CRIT_LOCAL = 8'h20;

	// ----------------------------------------------------------------
	// alert_flags field positions
	// ----------------------------------------------------------------
	localparam int BIT_BUSY = 7;
	localparam int BIT_LOCAL_HIGH = 6;
	localparam int BIT_REMOTE_HIGH = 4;
	localparam int BIT_REMOTE_LOW = 3;
	localparam int BIT_REMOTE_OPEN = 2;
	localparam int BIT_REMOTE_CRIT = 1;
	localparam int BIT_LOCAL_CRIT = 0;

	// ----------------------------------------------------------------
	// operation_setup field positions
	// ----------------------------------------------------------------
	localparam int CFG_ALERT_MASK = 7;
	localparam int CFG_MODE = 6;
	localparam int CFG_REMOTE_EN = 2;
	localparam int CFG_CRIT_UNLOCK = 1;
	localparam int CFG_FAULT_Q = 0;

	// ----------------------------------------------------------------
	// reset values and bit groups
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_STATUS = 8'h00;
	localparam logic [7:0] RST_CFG = 8'h05;
	localparam logic [7:0] RST_CRIT = 8'h00;
	localparam logic [7:0] CFG_WRITABLE = 8'hc7;
	localparam logic [7:0] LIMIT_FLAGS = 8'h5b;
	localparam logic [7:0] ALERT_SRC = 8'h58;
	localparam logic [7:0] CRIT_SRC = 8'h03;

	// ----------------------------------------------------------------
	// fault queue
	// ----------------------------------------------------------------
	localparam int FQ_CHANNELS = 3;
	localparam int FQ_HIGH = 0;
	localparam int FQ_LOW = 1;
	localparam int FQ_CRIT = 2;
	localparam logic [1:0] FQ_PRIOR = 2'h2;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		CONV_IDLE = 2'b01,
		CONV_BUSY = 2'b10
	} tasc_conv_t;

	typedef struct packed {
		logic [7:0] addr;
		logic wr;
		logic rd;
		logic [7:0] wdata;
	} tasc_reg_req_t;

	typedef struct packed {
		logic [7:0] local_temp;
		logic [10:0] remote_temp;
		logic remote_open;
	} tasc_result_t;

	typedef struct packed {
		logic [7:0] local_high;
		logic [10:0] remote_high;
		logic [10:0] remote_low;
	} tasc_limits_t;

	typedef struct packed {
		logic [FQ_CHANNELS-1:0][1:0] run;
	} tasc_fq_state_t;

	typedef struct packed {
		tasc_conv_t st;
		logic [7:0] flags;
		logic [7:0] cfg;
		logic [7:0] pend_cfg;
		logic pend_v;
		logic [7:0] crit_remote;
		logic [7:0] crit_local;
		logic [7:0] rdata;
		logic start_p;
		logic abort_p;
		logic ara_ack;
		logic alert_oe;
		logic crit_oe;
	} tasc_core_state_t;

endpackage

//--- sim/tasc_host_model.sv
// register host model: byte writes, byte reads and alert response requests
module tasc_host_model (
	// clock
	input wire logic clk,
	// register port
	output tasc_pkg::tasc_reg_req_t req,
	input wire logic [7:0] reg_rdata,
	// alert response
	output logic ara_req,
	input wire logic ara_ack
);
	timeunit 1ns;
	timeprecision 100ps;

	// idle bus at time zero
	initial begin
		req = '0;
		ara_req = 1'b0;
	end

	// one write strobe; released lines show inverted data, not the old value
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk);
		#1 req = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: v};
		@(posedge clk);
		#1 req = '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: ~v};
	endtask

	// read strobe; data is taken one edge later, then the strobe drops
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge clk);
		#1 req = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
		@(posedge clk);
		#1 v = reg_rdata;
		req = '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: 8'hff};
	endtask

	// alert response request, answer sampled on the next edge
	task automatic ara(output logic ack);
		@(posedge clk);
		#1 ara_req = 1'b1;
		@(posedge clk);
		#1 ack = ara_ack;
		ara_req = 1'b0;
	endtask
endmodule

//--- sim/temp_alert_status_config_tb_top.sv
// self-checking bench of the status and setup registers
module temp_alert_status_config_tb_top;
	timeunit 1ns;
	timeprecision 100ps;

	logic clk = 1'b0;
	logic rst = 1'b1;
	logic conv_tick = 1'b0;
	logic conv_done = 1'b0;
	logic ara_req, ara_ack, conv_start, conv_abort, conv_remote_en;
	logic alert_o, alert_oe, crit_o, crit_oe, ack;
	logic [7:0] reg_rdata, d;
	tasc_pkg::tasc_reg_req_t req;
	tasc_pkg::tasc_result_t result = '0;
	tasc_pkg::tasc_limits_t limits;
	int err_total = 0;
	int total_checks = 0;
	int cyc = 0;
	int n_start = 0;
	int n_abort = 0;
	int k;

	// limits: local high 70, remote high 100h, remote low 010h
	assign limits = '{local_high: 8'h46, remote_high: 11'h100,
		remote_low: 11'h010};

	always #5 clk = ~clk;

	tasc_core u_tasc_core (.clk(clk), .rst(rst), .req(req),
		.reg_rdata(reg_rdata), .ara_req(ara_req), .ara_ack(ara_ack),
		.conv_tick(conv_tick), .conv_done(conv_done), .result(result),
		.limits(limits), .conv_start(conv_start), .conv_abort(conv_abort),
		.conv_remote_en(conv_remote_en), .alert_o(alert_o),
		.alert_oe(alert_oe), .crit_o(crit_o), .crit_oe(crit_oe));

	tasc_host_model u_tasc_host_model (.clk(clk), .req(req),
		.reg_rdata(reg_rdata), .ara_req(ara_req), .ara_ack(ara_ack));

	// pulse counters and hang guard, well above the run length
	always @(posedge clk) begin
		cyc++;
		if (conv_start === 1'b1) n_start++;
		if (conv_abort === 1'b1) n_abort++;
		if (cyc == 20000) begin
			err_total++;
			end_sim();
		end
	end

	task automatic chk(string nm, logic [7:0] s, logic [7:0] e);
		total_checks++;
		if (s !== e) begin
			err_total++;
			$display("unexpected %s expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic rc(string nm, logic [7:0] a, logic [7:0] e);
		u_tasc_host_model.rd(a, d);
		chk(nm, d, e);
	endtask

	task automatic wr(logic [7:0] a, logic [7:0] v);
		u_tasc_host_model.wr(a, v);
	endtask

	// period tick; start is expected exactly one edge later
	task automatic start_conv;
		@(posedge clk);
		#1 conv_tick = 1'b1;
		@(posedge clk);
		#1 conv_tick = 1'b0;
		chk("conv_start", {7'h0, conv_start}, 8'h01);
	endtask

	// converter answers slowly, result valid with the done pulse
	task automatic finish_conv(logic [7:0] l, logic [10:0] r, logic o);
		repeat (3) @(posedge clk);
		#1 result = '{local_temp: l, remote_temp: r, remote_open: o};
		conv_done = 1'b1;
		@(posedge clk);
		#1 conv_done = 1'b0;
		@(posedge clk);
		#1;
	endtask

	task automatic conv(logic [7:0] l, logic [10:0] r, logic o);
		start_conv();
		finish_conv(l, r, o);
	endtask

	task automatic end_sim;
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// reset values, reserved bits, shutdown and one-shot
	// ----------------------------------------------------------------
	task automatic t_reset_mode;
		rc("status", tasc_pkg::ADDR_STATUS, 8'h00);
		rc("setup", tasc_pkg::ADDR_CFG, 8'h05);
		chk("remote_en", {7'h0, conv_remote_en}, 8'h01);
		rc("unmapped", 8'h55, 8'h00);
		wr(tasc_pkg::ADDR_CFG_ALT, 8'hff);
		rc("setup", tasc_pkg::ADDR_CFG, 8'hc7);
		k = n_start;
		@(posedge clk);
		#1 conv_tick = 1'b1;
		@(posedge clk);
		#1 conv_tick = 1'b0;
		repeat (4) @(posedge clk);
		chk("starts", 8'(n_start), 8'(k));
		wr(tasc_pkg::ADDR_ONESHOT, 8'h01);
		@(posedge clk);
		#1 chk("starts", 8'(n_start), 8'(k + 1));
		finish_conv(8'h10, 11'h020, 1'b0);
		// critical limits still at reset zero, so 10h is already critical
		rc("status", tasc_pkg::ADDR_STATUS, 8'h01);
	endtask

	// ----------------------------------------------------------------
	// limit flags, pins, read clear, mask, lock, response address
	// ----------------------------------------------------------------
	task automatic t_flags;
		wr(tasc_pkg::ADDR_CFG, 8'h06);
		wr(tasc_pkg::ADDR_CRIT_REMOTE, 8'h7f);
		wr(tasc_pkg::ADDR_CRIT_LOCAL, 8'h70);
		wr(tasc_pkg::ADDR_CFG, 8'h04);
		// locked: this zero must not replace 70h
		wr(tasc_pkg::ADDR_CRIT_LOCAL, 8'h00);
		start_conv();
		rc("busy", tasc_pkg::ADDR_STATUS, 8'h80);
		finish_conv(8'h60, 11'h300, 1'b1);
		chk("alert_oe", {7'h0, alert_oe}, 8'h01);
		chk("crit_oe", {7'h0, crit_oe}, 8'h01);
		chk("alert_o", {7'h0, alert_o}, 8'h00);
		chk("crit_o", {7'h0, crit_o}, 8'h00);
		rc("status", tasc_pkg::ADDR_STATUS, 8'h56);
		rc("setup", tasc_pkg::ADDR_CFG, 8'h84);
		chk("alert_oe", {7'h0, alert_oe}, 8'h00);
		chk("crit_oe", {7'h0, crit_oe}, 8'h00);
		rc("status", tasc_pkg::ADDR_STATUS, 8'h04);
		wr(tasc_pkg::ADDR_CFG, 8'h04);
		conv(8'h10, 11'h020, 1'b1);
		chk("alert_oe", {7'h0, alert_oe}, 8'h00);
		chk("crit_oe", {7'h0, crit_oe}, 8'h00);
		conv(8'h10, 11'h005, 1'b0);
		chk("alert_oe", {7'h0, alert_oe}, 8'h01);
		u_tasc_host_model.ara(ack);
		chk("ara_ack", {7'h0, ack}, 8'h01);
		chk("alert_oe", {7'h0, alert_oe}, 8'h00);
		rc("setup", tasc_pkg::ADDR_CFG, 8'h84);
		rc("status", tasc_pkg::ADDR_STATUS, 8'h08);
	endtask

	// ----------------------------------------------------------------
	// fault queue on remote only, local immediate
	// ----------------------------------------------------------------
	task automatic t_queue;
		wr(tasc_pkg::ADDR_CFG, 8'h05);
		for (int i = 0; i < 3; i++) begin
			conv(8'h75, 11'h300, 1'b0);
			rc("status", tasc_pkg::ADDR_STATUS,
				(i < 2) ? 8'h41 : 8'h53);
		end
	endtask

	// ----------------------------------------------------------------
	// setup write while busy: restart unless shutdown, applied at done
	// ----------------------------------------------------------------
	task automatic t_busy_write;
		k = n_abort;
		start_conv();
		wr(tasc_pkg::ADDR_CFG, 8'h01);
		repeat (3) @(posedge clk);
		chk("aborts", 8'(n_abort), 8'(k + 1));
		chk("remote_en", {7'h0, conv_remote_en}, 8'h01);
		finish_conv(8'h10, 11'h020, 1'b0);
		chk("remote_en", {7'h0, conv_remote_en}, 8'h00);
		wr(tasc_pkg::ADDR_CFG, 8'h05);
		start_conv();
		wr(tasc_pkg::ADDR_CFG, 8'h45);
		repeat (3) @(posedge clk);
		chk("aborts", 8'(n_abort), 8'(k + 1));
		finish_conv(8'h10, 11'h020, 1'b0);
		rc("setup", tasc_pkg::ADDR_CFG, 8'h45);
	endtask

	// main sequence
	initial begin
		repeat (3) @(posedge clk);
		#1 rst = 1'b0;
		t_reset_mode();
		t_flags();
		t_queue();
		t_busy_write();
		end_sim();
	end
endmodule
